// ### identify_cfg.svh
// Word indices, field positions and fixed values of the identify capability words
`ifndef IDENTIFY_CFG_SVH
`define IDENTIFY_CFG_SVH

// ==========================================================================
// Word indices
`define IDW_QUEUE_DEPTH     8'h4B
`define IDW_SERIAL_CAPS     8'h4C
`define IDW_SER_FEAT_SUP    8'h4E
`define IDW_SER_FEAT_ENA    8'h4F
`define IDW_CMD_SUP_1       8'h52
`define IDW_CMD_SUP_2       8'h53
`define IDW_CMD_SUP_3       8'h54
`define IDW_CMD_ENA_1       8'h55
`define IDW_CMD_ENA_2       8'h56
`define IDW_CMD_ENA_3       8'h57
`define IDW_UDMA_MODES      8'h58
`define IDW_ERASE_TIME      8'h59
`define IDW_MASTER_REV      8'h5C
`define IDW_SEC_STATUS      8'h80

// ==========================================================================
// Field positions and fixed values
`define QDEPTH_MSB          4
`define VALID_SIG_BIT       14
`define VALID_ZERO_BIT      15
`define PACKET_BIT          4
`define UDMA_SEL_LSB        8
`define UDMA_MODES          7
`define SEC_LEVEL_MAX_BIT   8
`define SEC_EXPIRED_BIT     4
`define MASTER_REV_NONE     16'hFFFF
`define WORD_ZERO           16'h0000
`define ONE_HOT7_NONE       7'h00

`endif

// ### identify_pkg.sv
// Types shared by the identify capability word generator
package identify_pkg;

    // ======================================================================
    // Live configuration of the drive
    typedef struct packed {
        logic [5:0] ser_feat_on;
        logic [15:0] cmd1_on;
        logic [15:0] cmd2_on;
        logic [6:0] udma_sel;
        logic       mdma_sel;
        logic       sec_enabled;
        logic       sec_level_max;
        logic       sec_locked;
        logic       sec_frozen;
        logic       sec_expired;
        logic [15:0] master_rev;
    } live_cfg_type;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_LOOK = 3'b010,
        RD_DONE = 3'b100
    } rd_state_type;

endpackage : identify_pkg

// ### identify_capability_words.sv
// Identify words 75..128: capability, feature and security reporting
//
// Functional notes
// - Queue depth word: depth minus one, low bits
// - Caps word: event counters, host PM, queuing
// - Caps word: gen2, gen1 speed; bit0 zero
// - Feature support word bits 6..1, rest zero
// - Feature enabled word mirrors support layout
// - Supported words two, three: valid signature
// - Packet feature bit reads zero
// - First supported word command flags
// - Second supported word flush, overlay, 48-bit
// - Third supported word name, logging, self-test
// - First enabled word reports live enables
// - Third enabled word valid signature
// - Never more than one DMA mode selected
// - Selected ultra mode one-hot bits 14..8
// - Supported ultra modes cumulative bits 6..0
// - No ultra support gives zero word
// - Erase time in two-minute units
// - Master revision, all ones when unsupported
// - Level bit set only enabled at maximum
// - Expired count aborts unlock and erase
// - Security status flag bits 5..0
`timescale 1ns/10ps
`include "identify_cfg.svh"

module identify_capability_words #(
    parameter logic [5:0]  QUEUE_DEPTH    = 6'd32,
    parameter logic        EVENT_CNT_SUP  = 1'b0,
    parameter logic        HOST_PM_SUP    = 1'b1,
    parameter logic        NCQ_SUP        = 1'b1,
    parameter logic        GEN2_SUP       = 1'b1,
    parameter logic        GEN1_SUP       = 1'b1,
    parameter logic [5:0]  SER_FEAT_SUP   = 6'h08,
    parameter logic [15:0] CMD1_SUP       = 16'h740B,
    parameter logic [12:0] CMD2_SUP       = 13'h1C00,
    parameter logic [13:0] CMD3_SUP       = 14'h0123,
    parameter logic [2:0]  UDMA_MAX       = 3'd6,
    parameter logic        UDMA_SUP       = 1'b1,
    parameter logic        SEC_SUP        = 1'b1,
    parameter logic        ENH_ERASE_SUP  = 1'b0,
    parameter logic        REV_SUP        = 1'b1,
    parameter logic [15:0] ERASE_UNITS    = 16'h0001
) (
    // Clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    // Live configuration
    input  wire identify_pkg::live_cfg_type cfg_i,
    // Identify word request
    input  wire logic                       rd_req_i,
    input  wire logic [7:0]                 rd_index_i,
    output logic                            rd_ack_o,
    output logic [15:0]                     rd_data_o,
    // Security command gate and selection error
    output logic                            sec_cmd_abort_o,
    output logic                            dma_sel_err_o
);

    // ======================================================================
    // Helpers
    function automatic logic [6:0] cumulative(input logic [2:0] top, input logic sup);
        logic [6:0] m;
        m = `ONE_HOT7_NONE;
        for (int i = 0; i < `UDMA_MODES; i++) begin
            if (sup && (3'(i) <= top)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : cumulative

    function automatic logic is_one_hot_or_zero(input logic [6:0] v);
        return (v & (v - 7'd1)) == `ONE_HOT7_NONE;
    endfunction : is_one_hot_or_zero

    // ======================================================================
    // Word assembly
    logic [15:0] word_next;
    logic [15:0] rd_data_reg;
    logic        rd_ack_reg;
    logic [6:0]  udma_sel_safe;
    logic        sel_conflict;
    identify_pkg::rd_state_type state_reg;

    always_comb begin
        sel_conflict  = cfg_i.mdma_sel || !is_one_hot_or_zero(cfg_i.udma_sel);
        udma_sel_safe = (sel_conflict || !UDMA_SUP) ? `ONE_HOT7_NONE : cfg_i.udma_sel;
    end

    always_comb begin
        word_next = `WORD_ZERO;
        unique case (rd_index_i)
            `IDW_QUEUE_DEPTH: word_next[`QDEPTH_MSB:0] = 5'(QUEUE_DEPTH - 6'd1);
            `IDW_SERIAL_CAPS: word_next = {5'h00, EVENT_CNT_SUP, HOST_PM_SUP, NCQ_SUP,
                                           5'h00, GEN2_SUP, GEN1_SUP, 1'b0};
            `IDW_SER_FEAT_SUP: word_next = {9'h000, SER_FEAT_SUP, 1'b0};
            `IDW_SER_FEAT_ENA: word_next = {9'h000, cfg_i.ser_feat_on & SER_FEAT_SUP, 1'b0};
            `IDW_CMD_SUP_1: begin
                word_next = CMD1_SUP;
                word_next[`PACKET_BIT] = 1'b0;
            end
            `IDW_CMD_SUP_2: begin
                word_next = {2'b00, CMD2_SUP[12:0] & 13'h1C00, 1'b0};
                word_next[12:10] = CMD2_SUP[12:10];
                word_next[13] = CMD2_SUP[12] & 1'b1;
                word_next[`VALID_SIG_BIT]  = 1'b1;
                word_next[`VALID_ZERO_BIT] = 1'b0;
            end
            `IDW_CMD_SUP_3: begin
                word_next = {2'b00, CMD3_SUP};
                word_next[`VALID_SIG_BIT]  = 1'b1;
                word_next[`VALID_ZERO_BIT] = 1'b0;
            end
            `IDW_CMD_ENA_1: begin
                word_next = cfg_i.cmd1_on & CMD1_SUP;
                word_next[1] = cfg_i.sec_enabled & SEC_SUP;
                word_next[`PACKET_BIT] = 1'b0;
            end
            // only bit 0 is defined here
            `IDW_CMD_ENA_2: word_next[0] = cfg_i.cmd2_on[0];
            `IDW_CMD_ENA_3: begin
                word_next[`VALID_SIG_BIT]  = 1'b1;
                word_next[`VALID_ZERO_BIT] = 1'b0;
            end
            `IDW_UDMA_MODES: word_next = UDMA_SUP ?
                {1'b0, udma_sel_safe, 1'b0, cumulative(UDMA_MAX, UDMA_SUP)} : `WORD_ZERO;
            `IDW_ERASE_TIME: word_next = SEC_SUP ? ERASE_UNITS : `WORD_ZERO;
            `IDW_MASTER_REV: word_next = REV_SUP ? cfg_i.master_rev : `MASTER_REV_NONE;
            `IDW_SEC_STATUS: begin
                word_next[`SEC_LEVEL_MAX_BIT] = cfg_i.sec_enabled & cfg_i.sec_level_max & SEC_SUP;
                word_next[5] = ENH_ERASE_SUP & SEC_SUP;
                word_next[`SEC_EXPIRED_BIT] = cfg_i.sec_expired & SEC_SUP;
                word_next[3] = cfg_i.sec_frozen & SEC_SUP;
                word_next[2] = cfg_i.sec_locked & SEC_SUP;
                word_next[1] = cfg_i.sec_enabled & SEC_SUP;
                word_next[0] = SEC_SUP;
            end
            default: word_next = `WORD_ZERO;
        endcase
    end

    // ======================================================================
    // Request handshake: word latched and ack raised on the same edge after the request
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_reg <= identify_pkg::RD_IDLE;
        end else begin
            unique case (state_reg)
                identify_pkg::RD_IDLE: if (rd_req_i) begin
                    state_reg <= identify_pkg::RD_LOOK;
                end
                identify_pkg::RD_LOOK: state_reg <= identify_pkg::RD_DONE;
                identify_pkg::RD_DONE: state_reg <= identify_pkg::RD_IDLE;
                default: state_reg <= identify_pkg::RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_data_reg <= `WORD_ZERO;
            rd_ack_reg  <= 1'b0;
        end else begin
            rd_ack_reg <= (state_reg == identify_pkg::RD_IDLE) && rd_req_i;
            if ((state_reg == identify_pkg::RD_IDLE) && rd_req_i) begin
                rd_data_reg <= word_next;
            end
        end
    end

    assign rd_ack_o  = rd_ack_reg;
    assign rd_data_o = rd_data_reg;

    // ======================================================================
    // Security gate and selection error
    logic abort_reg;
    logic dma_err_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            abort_reg   <= 1'b0;
            dma_err_reg <= 1'b0;
        end else begin
            abort_reg   <= cfg_i.sec_expired & SEC_SUP;
            dma_err_reg <= sel_conflict;
        end
    end

    assign sec_cmd_abort_o = abort_reg;
    assign dma_sel_err_o   = dma_err_reg;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    ack_follows_req_a: assert property (
        (state_reg == identify_pkg::RD_IDLE && rd_req_i) |=> rd_ack_o)
        else $error("ack missing after request");
    udma_one_hot_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_UDMA_MODES) |-> is_one_hot_or_zero(rd_data_o[14:8]))
        else $error("more than one ultra mode selected");
    udma_no_mdma_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_UDMA_MODES && $past(cfg_i.mdma_sel))
            |-> rd_data_o[14:8] == `ONE_HOT7_NONE)
        else $error("ultra mode selected with multiword");
    udma_cumulative_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_UDMA_MODES)
            |-> ((rd_data_o[6:0] & (rd_data_o[6:0] + 7'd1)) == `ONE_HOT7_NONE) && !rd_data_o[7])
        else $error("ultra support not cumulative");
    sig_valid_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_CMD_ENA_3) |-> rd_data_o[15:14] == 2'b01)
        else $error("enabled signature wrong");
    packet_zero_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_CMD_SUP_1) |-> !rd_data_o[`PACKET_BIT])
        else $error("packet bit set");
    level_bit_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_SEC_STATUS && !$past(cfg_i.sec_enabled))
            |-> !rd_data_o[`SEC_LEVEL_MAX_BIT])
        else $error("level bit set while disabled");
    abort_track_a: assert property (
        (cfg_i.sec_expired && SEC_SUP) |=> sec_cmd_abort_o)
        else $error("abort not raised on expiry");
    caps_bit0_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_SERIAL_CAPS) |-> !rd_data_o[0])
        else $error("caps bit 0 set");

    // ======================================================================
    // Word layout checks, judged on the word latched at the taken request; dma_conflict_a judges dma_sel_err_o
    qdepth_word_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_QUEUE_DEPTH)
            |-> rd_data_o[15:`QDEPTH_MSB+1] == 11'h000 && rd_data_o[`QDEPTH_MSB:0] == 5'(QUEUE_DEPTH - 6'd1))
        else $error("queue depth word wrong");
    caps_flags_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_SERIAL_CAPS)
            |-> rd_data_o[10:8] == {EVENT_CNT_SUP, HOST_PM_SUP, NCQ_SUP} && rd_data_o[15:11] == 5'h00)
        else $error("caps flags wrong");
    caps_speed_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_SERIAL_CAPS)
            |-> rd_data_o[2:1] == {GEN2_SUP, GEN1_SUP} && rd_data_o[7:3] == 5'h00)
        else $error("caps speed bits wrong");
    feat_sup_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_SER_FEAT_SUP)
            |-> rd_data_o[15:7] == 9'h000 && !rd_data_o[0] && rd_data_o[6:1] == SER_FEAT_SUP)
        else $error("feature support word wrong");
    feat_ena_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_SER_FEAT_ENA)
            |-> rd_data_o[15:7] == 9'h000 && !rd_data_o[0]
                && rd_data_o[6:1] == ($past(cfg_i.ser_feat_on) & SER_FEAT_SUP))
        else $error("feature enabled word wrong");
    sup_sig_a: assert property (
        (rd_ack_o && ($past(rd_index_i) == `IDW_CMD_SUP_2 || $past(rd_index_i) == `IDW_CMD_SUP_3))
            |-> rd_data_o[15:14] == 2'b01)
        else $error("supported signature wrong");
    ena1_packet_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_CMD_ENA_1) |-> !rd_data_o[`PACKET_BIT])
        else $error("packet enable bit set");
    ena1_security_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_CMD_ENA_1)
            |-> rd_data_o[1] == ($past(cfg_i.sec_enabled) && SEC_SUP))
        else $error("security enable bit wrong");
    sup3_flags_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_CMD_SUP_3) |-> rd_data_o[13:0] == CMD3_SUP)
        else $error("third supported word flags wrong");
    dma_conflict_a: assert property (
        $past(cfg_i.mdma_sel) |-> dma_sel_err_o)
        else $error("selection conflict not flagged");
    erase_time_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_ERASE_TIME)
            |-> rd_data_o == (SEC_SUP ? ERASE_UNITS : `WORD_ZERO))
        else $error("erase time word wrong");
    sec_reserved_a: assert property (
        (rd_ack_o && $past(rd_index_i) == `IDW_SEC_STATUS)
            |-> rd_data_o[0] == SEC_SUP && rd_data_o[15:9] == 7'h00 && rd_data_o[7:6] == 2'b00)
        else $error("security status layout wrong");
    // Output word only moves on a taken request; ack lasts a single cycle
    data_hold_a: assert property (
        !(state_reg == identify_pkg::RD_IDLE && rd_req_i) |=> $stable(rd_data_o))
        else $error("read word moved without request");
    ack_pulse_a: assert property (
        rd_ack_o |=> !rd_ack_o)
        else $error("ack longer than one cycle");

    udma_read_c: cover property (rd_ack_o && $past(rd_index_i) == `IDW_UDMA_MODES);
    dma_err_c:   cover property (dma_sel_err_o);
    sec_read_c:  cover property (rd_ack_o && $past(rd_index_i) == `IDW_SEC_STATUS);
    abort_c:     cover property (sec_cmd_abort_o);

endmodule : identify_capability_words

// ### identify_host_model.sv
// Host-side reader of identify capability words
`timescale 1ns/10ps

module identify_host_model (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Bench control
    input  wire logic        go_i,
    input  wire logic [7:0]  index_i,
    output logic             done_o,
    output logic [15:0]      word_o,
    output logic             info_valid_o,
    output logic [16:0]      erase_min_o,
    // Identify word request
    input  wire logic        rd_ack_i,
    input  wire logic [15:0] rd_data_i,
    output logic             rd_req_o,
    output logic [7:0]       rd_index_o
);
    // ==========================================================================
    // Request held until the answer is sampled
    always_ff @(posedge clk_sys_i) begin
        done_o <= 1'b0;
        if (!rst_n_i) begin
            rd_req_o   <= 1'b0;
            rd_index_o <= 8'h00;
            word_o     <= 16'h0000;
        end else if (go_i && !rd_req_o) begin
            rd_req_o   <= 1'b1;
            rd_index_o <= index_i;
        end else if (rd_req_o && rd_ack_i) begin
            rd_req_o   <= 1'b0;
            // Released index changes so a stale value is never reused
            rd_index_o <= ~rd_index_o;
            word_o     <= rd_data_i;
            done_o     <= 1'b1;
        end
    end

    assign info_valid_o = (word_o != 16'hFFFF);
    assign erase_min_o = {word_o, 1'b0};
endmodule : identify_host_model

// ### identify_capability_words_tb_top.sv
// Self-checking bench for the identify capability word generator
`timescale 1ns/10ps

module identify_capability_words_tb_top;
    logic                       clk_sys_i = 1'b0;
    logic                       rst_n_i = 1'b0;
    identify_pkg::live_cfg_type cfg = '0;
    logic                       go = 1'b0;
    logic [7:0]                 idx_r = 8'h00;
    logic                       done, req, ack, abort, dma_err, info_ok;
    logic [7:0]                 rd_idx;
    logic [15:0]                word, data;
    logic [16:0]                erase_min;
    int                         n_mismatch = 0;
    int                         checked = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    identify_capability_words u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
        .rd_req_i(req), .rd_index_i(rd_idx), .rd_ack_o(ack), .rd_data_o(data),
        .sec_cmd_abort_o(abort), .dma_sel_err_o(dma_err));
    identify_host_model u_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go), .index_i(idx_r),
        .done_o(done), .word_o(word), .info_valid_o(info_ok), .erase_min_o(erase_min),
        .rd_ack_i(ack), .rd_data_i(data), .rd_req_o(req), .rd_index_o(rd_idx));

    // ==========================================================================
    // Shared helpers
    task automatic summarize;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic check16(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check16

    task automatic read_check(input logic [7:0] idx, input logic [15:0] exp);
        int n;
        @(posedge clk_sys_i);
        go <= 1'b1;
        idx_r <= idx;
        @(posedge clk_sys_i);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
        check16({1'b0, word}, {1'b0, exp});
    endtask : read_check

    // ==========================================================================
    // Scenarios
    task automatic static_words;
        logic [7:0]  ix [9] = '{8'h4B, 8'h4C, 8'h4E, 8'h52, 8'h53, 8'h54, 8'h57, 8'h59, 8'h30};
        logic [15:0] ex [9] = '{16'h001F, 16'h0306, 16'h0010, 16'h740B, 16'h7C00, 16'h4123,
                                16'h4000, 16'h0001, 16'h0000};
        for (int i = 0; i < 9; i++) begin
            read_check(ix[i], ex[i]);
        end
        read_check(8'h59, 16'h0001);
        check16(erase_min, 17'h0_0002);
        check16({16'h0000, info_ok}, 17'h0_0001);
    endtask : static_words

    task automatic live_enables;
        @(posedge clk_sys_i);
        cfg.ser_feat_on <= 6'h3F;
        cfg.cmd1_on <= 16'hFFFF;
        read_check(8'h4F, 16'h0010);
        read_check(8'h55, 16'h7409);
        @(posedge clk_sys_i);
        cfg.ser_feat_on <= 6'h00;
        cfg.cmd1_on <= 16'h0001;
        read_check(8'h4F, 16'h0000);
        read_check(8'h55, 16'h0001);
    endtask : live_enables

    task automatic udma_modes;
        for (int m = 0; m < 7; m++) begin
            @(posedge clk_sys_i);
            cfg.udma_sel <= 7'h01 << m;
            read_check(8'h58, (16'h0100 << m) | 16'h007F);
        end
        @(posedge clk_sys_i);
        cfg.mdma_sel <= 1'b1;
        read_check(8'h58, 16'h007F);
        check16({16'h0000, dma_err}, 17'h0_0001);
    endtask : udma_modes

    task automatic sec_case(input logic [4:0] s, input logic [15:0] exp);
        @(posedge clk_sys_i);
        {cfg.sec_enabled, cfg.sec_level_max, cfg.sec_locked, cfg.sec_frozen, cfg.sec_expired} <= s;
        read_check(8'h80, exp);
        check16({16'h0000, abort}, {16'h0000, s[0]});
    endtask : sec_case

    task automatic security_words;
        @(posedge clk_sys_i);
        cfg.master_rev <= 16'h1234;
        read_check(8'h5C, 16'h1234);
        @(posedge clk_sys_i);
        cfg.master_rev <= 16'hFFFF;
        read_check(8'h5C, 16'hFFFF);
        check16({16'h0000, info_ok}, 17'h0_0000);
        sec_case(5'b1_1101, 16'h0117);
        sec_case(5'b1_0010, 16'h000B);
        sec_case(5'b0_1000, 16'h0001);
    endtask : security_words

    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        static_words();
        live_enables();
        udma_modes();
        security_words();
        summarize();
    end
endmodule : identify_capability_words_tb_top
